// ---- inc/sei_pkg.sv ----
// shared constants and carrier types for the synthesizer event interrupt block
package sei_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_ENABLES = 8'hA5;
    localparam logic [7:0]  IDX_GATES0  = 8'hA6;
    localparam logic [7:0]  IDX_GATES1  = 8'hA7;
    localparam logic [7:0]  IDX_CONFIG  = 8'hC0;
    localparam logic [7:0]  IDX_STATUS  = 8'hC1;
    localparam logic [7:0]  IDX_CLEAR   = 8'hC2;
    // writable bit masks, reserved bits read as zero
    localparam logic [7:0]  MASK_ENABLES = 8'h0F;
    localparam logic [7:0]  MASK_GATES0  = 8'h34;
    localparam logic [7:0]  MASK_GATES1  = 8'hF4;
    localparam logic [7:0]  MASK_CONFIG  = 8'h03;
    // field positions
    localparam int          BIT_LOCK   = 2;
    localparam int          BIT_ALIGNA = 4;
    localparam int          BIT_IRQON  = 0;
    localparam int          BIT_LEVEL  = 1;
    localparam int          NUM_SYNTH  = 4;
    localparam int          NUM_MON    = 2;
    // reset values
    localparam logic [7:0]  RST_REG    = 8'h00;
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;

    // monitored status of one synthesizer: alignment per divider (A..D) and lock
    typedef struct packed {
        logic [3:0] alignDone;
        logic       lockChange;
    } sei_mon_t;
endpackage

// ---- design/sei_irq_mask.sv ----
// synthesizer event interrupt masking with apb register access
// Behaviour
// - four per-synthesizer enable bits, bits 7:4 reserved
// - enables count only while interrupt function on
// - disabled synthesizer never interrupts nor sets fail
// - enabled synthesizer: gated change sets fail, interrupts
// - gate bit 2 selects lock status changes
// - gate bit 4 selects divider A alignment changes
// - first synthesizer: bit 5 gates divider B
// - second synthesizer: bits 7:4 dividers, bit 2 lock
// - rising and falling transitions both count
// - level mode holds pin until host clears
// - edge mode gives short pulse per interrupt
//
// Decided for this implementation: register access over APB.
module sei_irq_mask (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        reset_n,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // synthesizer monitors, index 0 is the first synthesizer
    input  wire sei_pkg::sei_mon_t [sei_pkg::NUM_MON-1:0] monStatus,
    // interrupt towards the host, active high
    output logic                             irqOut
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic [7:0]  enables_r;
    logic [7:0]  gates0_r;
    logic [7:0]  gates1_r;
    logic [7:0]  config_r;
    logic [3:0]  fail_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        setupPhase;
    logic        wrStrobe;
    logic [7:0]  regIdx;
    logic        mapped;
    logic [7:0]  rdByte;
    logic [3:0]  clearVec;

    assign setupPhase = psel && !penable;
    assign wrStrobe   = psel && penable && pwrite && pready_r && !pslverr_r;
    assign regIdx     = paddr[9:2];

    always_comb
    begin
        mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
        rdByte = sei_pkg::RST_REG;
        case (regIdx)
            sei_pkg::IDX_ENABLES: rdByte = enables_r;
            sei_pkg::IDX_GATES0:  rdByte = gates0_r;
            sei_pkg::IDX_GATES1:  rdByte = gates1_r;
            sei_pkg::IDX_CONFIG:  rdByte = config_r;
            sei_pkg::IDX_STATUS:  rdByte = {4'h0, fail_r};
            sei_pkg::IDX_CLEAR:   rdByte = sei_pkg::RST_REG;
            default:              mapped = 1'b0;
        endcase
    end

    // zero wait state: answer is prepared in the setup cycle
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata_r  <= sei_pkg::RST_WORD;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= setupPhase;
            pslverr_r <= setupPhase && !mapped;
            if (setupPhase && !pwrite && mapped)
                prdata_r <= {24'h00_0000, rdByte};
            else if (setupPhase)
                prdata_r <= sei_pkg::RST_WORD;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enables_r <= sei_pkg::RST_REG;
            gates0_r  <= sei_pkg::RST_REG;
            gates1_r  <= sei_pkg::RST_REG;
            config_r  <= sei_pkg::RST_REG;
        end
        else if (wrStrobe)
        begin
            case (regIdx)
                sei_pkg::IDX_ENABLES: enables_r <= pwdata[7:0] & sei_pkg::MASK_ENABLES;
                sei_pkg::IDX_GATES0:  gates0_r  <= pwdata[7:0] & sei_pkg::MASK_GATES0;
                sei_pkg::IDX_GATES1:  gates1_r  <= pwdata[7:0] & sei_pkg::MASK_GATES1;
                sei_pkg::IDX_CONFIG:  config_r  <= pwdata[7:0] & sei_pkg::MASK_CONFIG;
                default:              config_r  <= config_r;
            endcase
        end
    end

    // write one to clear; only at the access edge
    assign clearVec = (wrStrobe && regIdx == sei_pkg::IDX_CLEAR) ? pwdata[3:0] : 4'h0;

    // ------------------------------------------------------------
    // change detection
    // ------------------------------------------------------------
    logic                  primed_r;
    sei_pkg::sei_mon_t [sei_pkg::NUM_MON-1:0] prevStatus_r;
    sei_pkg::sei_mon_t [sei_pkg::NUM_MON-1:0] changed;
    logic                  irqOn;
    logic                  levelMode;

    assign irqOn     = config_r[sei_pkg::BIT_IRQON];
    assign levelMode = config_r[sei_pkg::BIT_LEVEL];

    // first sample after reset only primes the history, so a status that is
    // already high at reset does not look like a change
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            primed_r     <= 1'b0;
            prevStatus_r <= '0;
        end
        else
        begin
            primed_r     <= 1'b1;
            prevStatus_r <= monStatus;
        end
    end

    // xor catches 0-to-1 and 1-to-0 alike
    assign changed = primed_r ? (monStatus ^ prevStatus_r) : '0;

    // ------------------------------------------------------------
    // event gating and sticky fail bits
    // ------------------------------------------------------------
    logic [3:0] eventHit;
    logic [3:0] setVec;

    always_comb
    begin
        eventHit    = 4'h0;
        eventHit[0] = (changed[0].lockChange && gates0_r[sei_pkg::BIT_LOCK])
                    | (|(changed[0].alignDone[1:0]
                         & gates0_r[sei_pkg::BIT_ALIGNA +: 2]));
        eventHit[1] = (changed[1].lockChange && gates1_r[sei_pkg::BIT_LOCK])
                    | (|(changed[1].alignDone
                         & gates1_r[sei_pkg::BIT_ALIGNA +: 4]));
    end

    // synthesizers 2 and 3 have enables but no monitor inputs here
    assign setVec = irqOn ? (eventHit & enables_r[3:0]) : 4'h0;

    // a set in the same cycle as its clear wins
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            fail_r <= 4'h0;
        else
            fail_r <= (fail_r & ~clearVec) | setVec;
    end

    // ------------------------------------------------------------
    // interrupt pin
    // ------------------------------------------------------------
    logic irqOut_r;

    // level mode: held until the host clears every enabled fail bit;
    // edge mode: one cycle per cycle in which a fail bit is set
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            irqOut_r <= 1'b0;
        else if (levelMode)
            irqOut_r <= irqOn && |(fail_r & enables_r[3:0]);
        else
            irqOut_r <= |setVec;
    end

    assign irqOut = irqOut_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence lockArmed0;
        primed_r && irqOn && enables_r[0] && gates0_r[sei_pkg::BIT_LOCK];
    endsequence

    sequence lockFell0;
        lockArmed0 ##0 (prevStatus_r[0].lockChange && !monStatus[0].lockChange);
    endsequence

    synth_off_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(fail_r[0]) |-> $past(enables_r[0]))
        else $error("fail bit rose while synthesizer disabled");

    global_off_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        ((fail_r & ~$past(fail_r)) != 4'h0) |-> $past(irqOn))
        else $error("fail bit rose while interrupt function off");

    lock_gate_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        (lockArmed0 ##0 $changed(monStatus[0].lockChange)) |=> fail_r[0])
        else $error("gated lock change did not set fail bit");

    lock_fall_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        lockFell0 |=> (fail_r[0] ##1 (fail_r[0] || $past(clearVec[0]))))
        else $error("falling lock status was not counted");

    align_b_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        (primed_r && irqOn && enables_r[0] && gates0_r[sei_pkg::BIT_ALIGNA + 1]
         && $changed(monStatus[0].alignDone[1])) |=> fail_r[0])
        else $error("divider B alignment change missed");

    synth1_d_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        (primed_r && irqOn && enables_r[1] && gates1_r[sei_pkg::BIT_ALIGNA + 3]
         && $changed(monStatus[1].alignDone[3])) |=> fail_r[1])
        else $error("second synthesizer divider D change missed");

    sticky_hold_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fail_r[1] && !clearVec[1]) |=> fail_r[1])
        else $error("fail bit dropped without a clear");

    level_hold_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        (levelMode && irqOn && (fail_r & enables_r[3:0]) != 4'h0 && !wrStrobe)
        |=> (irqOut ##1 irqOut))
        else $error("level interrupt dropped before clear");

    edge_pulse_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!$past(levelMode) && irqOut) |-> $past(setVec != 4'h0))
        else $error("edge pulse without an event");

    // ------------------------------------------------------------
    // checks on detection, masking, priming, clearing, register writes, pin shape and bus timing
    // ------------------------------------------------------------
    sequence alignArmed0;
        primed_r && irqOn && enables_r[0] && gates0_r[sei_pkg::BIT_ALIGNA];
    endsequence

    sequence lockArmed1;
        primed_r && irqOn && enables_r[1] && gates1_r[sei_pkg::BIT_LOCK];
    endsequence

    align_diva_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        (alignArmed0 ##0 $changed(monStatus[0].alignDone[0])) |=> fail_r[0])
        else $error("divider A alignment change missed");

    synth1_lock_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        (lockArmed1 ##0 $changed(monStatus[1].lockChange)) |=> fail_r[1])
        else $error("second synthesizer lock change missed");

    // a masked lock change must leave a clear fail bit alone
    lock_masked_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!gates0_r[sei_pkg::BIT_LOCK] && $stable(monStatus[0].alignDone[1:0]) && !fail_r[0])
        |=> !fail_r[0])
        else $error("masked lock change set the fail bit");

    irq_off_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        !irqOn |=> !irqOut)
        else $error("interrupt pin raised while function off");

    clear_drop_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clearVec[0] && !setVec[0]) |=> !fail_r[0])
        else $error("cleared fail bit stayed set");

    // every fail bit that was set and not cleared is still set
    fail_keep_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        ((fail_r & ~clearVec) != 4'h0)
        |=> ((fail_r & $past(fail_r & ~clearVec)) == $past(fail_r & ~clearVec)))
        else $error("fail bit lost without a clear");

    level_drop_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        (levelMode && (fail_r & enables_r[3:0]) == 4'h0) |=> !irqOut)
        else $error("level interrupt stayed up after clear");

    // edge mode must return to inactive at once, never stretch a pulse
    edge_quiet_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!levelMode && setVec == 4'h0) |=> !irqOut)
        else $error("edge pulse stretched");

    prime_quiet_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        !primed_r |=> (fail_r == 4'h0))
        else $error("change counted on the priming cycle");

    enable_land_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        (wrStrobe && regIdx == sei_pkg::IDX_ENABLES)
        |=> (enables_r == $past(pwdata[7:0] & sei_pkg::MASK_ENABLES)))
        else $error("enable write did not land");

    // zero wait state: one access cycle per setup, never a stretched ready
    bus_ready_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
        setupPhase |=> (pready ##1 !pready))
        else $error("ready not a single cycle after setup");

endmodule

// ---- verif/sei_host_model.sv ----
// host-side model that watches the interrupt pin
module sei_host_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // interrupt pin and count acknowledge
    input  wire logic       irqOut,
    input  wire logic       ackCount,
    output logic      [7:0] highCycles
);
    timeunit 1ns;
    timeprecision 1ps;

    // counts sampled high cycles, so a stretched edge pulse shows up
    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n)
            highCycles <= 8'h00;
        else if (ackCount)
            highCycles <= 8'h00;
        else if (irqOut)
            highCycles <= highCycles + 8'h01;
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the synthesizer event interrupt block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    ref_clk = 1'b0;
    logic                    reset_n = 1'b0;
    logic                    psel = 1'b0;
    logic                    penable = 1'b0;
    logic                    pwrite = 1'b0;
    logic                    ackCount = 1'b0;
    logic [11:0]             paddr = 12'h000;
    logic [31:0]             pwdata = 32'h0, prdata, rd;
    logic                    pready, pslverr, irqOut, err, e;
    logic [7:0]              highCycles, en, g, cfg;
    sei_pkg::sei_mon_t [1:0] mon = '0;
    logic [7:0]              wmask [3] = '{8'h0F, 8'h34, 8'hF4};
    int                      miscompares = 0, check_count = 0, cycles = 0, s, ev;

    always #12.5 ref_clk = ~ref_clk;

    sei_irq_mask DUT (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .monStatus(mon), .irqOut(irqOut));
    sei_host_model host (.ref_clk(ref_clk), .reset_n(reset_n), .irqOut(irqOut),
        .ackCount(ackCount), .highCycles(highCycles));

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    // request held until pready is sampled high; no own limit, the cycle timeout ends a hang
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    // divider bits above B do not exist on the first synthesizer
    function automatic logic expSet(int s, int ev, logic [7:0] en, logic [7:0] g, logic [7:0] c);
        return c[0] & en[s] & g[ev == 0 ? 2 : 3 + ev] & (s == 1 || ev <= 2);
    endfunction

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            miscompares++;
            tally_and_finish;
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(21));
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, sei_pkg::IDX_ENABLES + 8'(i), 32'h0);
            check(rd, 32'h0, "reset value");
            apb(1'b1, sei_pkg::IDX_ENABLES + 8'(i), 32'hFFFF_FFFF);
            apb(1'b0, sei_pkg::IDX_ENABLES + 8'(i), 32'h0);
            check(rd, {24'h0, wmask[i]}, "reserved bits");
        end
        apb(1'b0, 8'hB0, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        repeat (60)
        begin
            s = $urandom_range(1, 0);
            ev = $urandom_range(4, 0);
            en = 8'($urandom);
            g = 8'($urandom);
            cfg = 8'($urandom) & 8'h01;
            e = expSet(s, ev, en, g, cfg);
            apb(1'b1, sei_pkg::IDX_ENABLES, {24'h0, en});
            apb(1'b1, sei_pkg::IDX_GATES0 + 8'(s), {24'h0, g});
            apb(1'b1, sei_pkg::IDX_CONFIG, {24'h0, cfg});
            apb(1'b1, sei_pkg::IDX_CLEAR, 32'h0F);
            ackCount <= 1'b1;
            @(posedge ref_clk);
            ackCount <= 1'b0;
            mon[s][ev] <= ~mon[s][ev];
            repeat (4) @(posedge ref_clk);
            apb(1'b0, sei_pkg::IDX_STATUS, 32'h0);
            check(rd, 32'(e) << s, "sticky fail");
            check({24'h0, highCycles}, {31'h0, e}, "edge pulse");
        end
        apb(1'b1, sei_pkg::IDX_CONFIG, 32'h03);
        apb(1'b1, sei_pkg::IDX_ENABLES, 32'h01);
        apb(1'b1, sei_pkg::IDX_GATES0, 32'h04);
        apb(1'b1, sei_pkg::IDX_CLEAR, 32'h0F);
        mon[0][0] <= ~mon[0][0];
        repeat (8) @(posedge ref_clk);
        check({31'h0, irqOut}, 32'h1, "level held");
        mon[0][0] <= ~mon[0][0];
        repeat (3) @(posedge ref_clk);
        check({31'h0, irqOut}, 32'h1, "level still held");
        apb(1'b1, sei_pkg::IDX_CLEAR, 32'h01);
        repeat (3) @(posedge ref_clk);
        check({31'h0, irqOut}, 32'h0, "level released");
        tally_and_finish;
    end
endmodule
